// ---- src/wtdc_pkg.sv ----
package wtdc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] WTDC_OFS_CMD = 8'h00;
    localparam logic [7:0] WTDC_OFS_STATUS = 8'h04;
    localparam logic [7:0] WTDC_OFS_R0_BASE = 8'h08;
    localparam logic [7:0] WTDC_OFS_R0_MASK = 8'h0c;
    localparam logic [7:0] WTDC_OFS_R1_BASE = 8'h10;
    localparam logic [7:0] WTDC_OFS_R1_MASK = 8'h14;
    localparam logic [7:0] WTDC_OFS_DEFAULT = 8'h18;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int WTDC_CMD_ENABLE_BIT = 0;
    localparam int WTDC_CMD_DISABLE_BIT = 1;
    localparam int WTDC_RGN_EN_BIT = 0;
    localparam int WTDC_RGN_CACHE_BIT = 1;
    localparam int WTDC_RGN_ADDR_LSB = 12;
    localparam int WTDC_ST_ENABLED_BIT = 0;
    localparam int WTDC_ST_BUSY_BIT = 1;
    localparam int WTDC_ST_WORDS_LSB = 4;
    localparam int WTDC_ST_KB_LSB = 8;
    localparam logic [31:0] WTDC_RGN_RST = 32'h0000_0000;
    localparam logic [31:0] WTDC_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] WTDC_DEF_RST = 32'h0000_0000;
    localparam logic WTDC_ENABLE_RST = 1'b0;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int WTDC_LINE_WORDS = 4;
    localparam int WTDC_LINE_BYTES = 16;
    localparam int WTDC_CACHE_KB_DEF = 2;

    typedef enum logic [2:0] {
        WTDC_SZ_BYTE = 3'h0,
        WTDC_SZ_HALF = 3'h1,
        WTDC_SZ_WORD = 3'h2,
        WTDC_SZ_DBL = 3'h3,
        WTDC_SZ_TRI = 3'h4,
        WTDC_SZ_QUAD = 3'h5
    } wtdc_size_t;

    typedef struct packed {
        logic valid;
        logic we;
        wtdc_size_t size;
        logic [31:0] addr;
        logic [127:0] wdata;
    } wtdc_lsu_req_t;

    typedef struct packed {
        logic done;
        logic [127:0] rdata;
    } wtdc_lsu_rsp_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [3:0] sel;
        logic [31:0] wdata;
    } wtdc_ext_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } wtdc_ext_rsp_t;

endpackage

// ---- src/wtdc_cache.sv ----
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps

// How it works
// RL1: Direct-mapped write-through allocate, four-word lines, valids.
// RL2: Capacity parameter of 1, 2 or 4 KB.
// RL3: Cached only if enabled and region allows.
// RL4: Reset leaves cache disabled, all valids cleared.
// RL5: Disabled cache serves every load externally.
// RL6: Enable, disable, status commands with attributes reply.
// RL7: Multi-word load, no hits: fetch all words.
// RL8: Aligned partial hit reloads every word externally.
// RL9: Unaligned partial hit fetches missing words only.
// RL10: Any miss writes all load words into cache.
// RL11: Full hit multi-word load uses no bus.
// RL12: Multi-word store writes every word externally.
// RL13: Load miss fetches only requested size.
// RL14: Cacheable-region sub-word loads widen to words.
// RL15: Every store appears on external bus.
// RL16: Store miss allocates line, sets written valids.
// RL17: Word store hit keeps tag, sets word valid.
// RL18: Sub-word hit on valid word updates, stays valid.
// RL19: Sub-word store to invalid word stays invalid.
// RL20: Sub-word store outside valid line: memory only.
// RL21: Region cache bit clear or disabled: uncached.
// RL22: Uncached store tag hit invalidates cached word.
// RL23: Disabled cache still invalidates on loads, stores.
// RL24: Index above 16-byte offset, rest is tag.
module wtdc_cache
    import wtdc_pkg::*;
#(
    parameter int CACHE_KB = WTDC_CACHE_KB_DEF
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire wtdc_lsu_req_t lsu_req_i,
    output logic lsu_ready_o,
    output wtdc_lsu_rsp_t lsu_rsp_o,
    output wtdc_ext_req_t ext_req_o,
    input wire wtdc_ext_rsp_t ext_rsp_i
);

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int LINES = CACHE_KB * 1024 / WTDC_LINE_BYTES; // RL2
    localparam int IDX_W = $clog2(LINES);
    localparam int TAG_W = 28 - IDX_W; // RL24

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_XFER = 4'b0100,
        ST_WAIT = 4'b1000
    } wtdc_state_t;

    function automatic logic [3:0] byte_lanes(input wtdc_size_t sz, input logic [1:0] a);
        logic [3:0] r;
        r = 4'hf;
        if (sz == WTDC_SZ_BYTE)
            r = 4'h1 << a;
        else if (sz == WTDC_SZ_HALF)
            r = a[1] ? 4'hc : 4'h3;
        return r;
    endfunction

    function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    function automatic logic in_region(input logic [31:0] a, input logic [31:0] base,
                                       input logic [31:0] mask);
        return base[WTDC_RGN_EN_BIT] &&
               (((a ^ base) & mask) >> WTDC_RGN_ADDR_LSB) == 32'h0000_0000;
    endfunction

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [31:0] data_mem [LINES*WTDC_LINE_WORDS];
    logic [TAG_W-1:0] tag_mem [LINES];
    logic [LINES-1:0] line_valid_reg;
    logic [3:0] word_valid_reg [LINES];

    logic enable_reg;
    logic [31:0] r0_base_reg;
    logic [31:0] r0_mask_reg;
    logic [31:0] r1_base_reg;
    logic [31:0] r1_mask_reg;
    logic [31:0] def_reg;

    wtdc_state_t state_reg;
    wtdc_lsu_req_t req_reg;
    logic [1:0] i_reg;
    logic [1:0] last_reg;
    logic [3:0] hit_reg;
    logic [3:0] need_reg;
    logic cacheable_reg;
    logic widen_reg;
    logic any_miss_reg;

    // ----------------------------------------------------------------
    // Lookup of the current word
    // ----------------------------------------------------------------
    logic [29:0] cur_wa;
    logic [IDX_W-1:0] cur_idx;
    logic [TAG_W-1:0] cur_tag;
    logic [1:0] cur_w;
    logic line_hit;
    logic word_hit;
    logic [31:0] cache_word;
    logic [31:0] sub_data;
    logic [3:0] sub_sel;
    logic sub_word;

    assign cur_wa = req_reg.addr[31:2] + 30'(i_reg);
    assign cur_idx = cur_wa[IDX_W+1:2]; // RL24
    assign cur_tag = cur_wa[29:IDX_W+2]; // RL24
    assign cur_w = cur_wa[1:0];
    assign line_hit = line_valid_reg[cur_idx] && tag_mem[cur_idx] == cur_tag;
    assign word_hit = line_hit && word_valid_reg[cur_idx][cur_w];
    assign cache_word = data_mem[{cur_idx, cur_w}];
    assign sub_word = req_reg.size == WTDC_SZ_BYTE || req_reg.size == WTDC_SZ_HALF;
    assign sub_sel = byte_lanes(req_reg.size, req_reg.addr[1:0]);
    assign sub_data = req_reg.wdata[31:0];

    // ----------------------------------------------------------------
    // Region qualification of the incoming request
    // ----------------------------------------------------------------
    logic rgn_cache;
    logic [1:0] req_last;

    always_comb
    begin
        if (in_region(lsu_req_i.addr, r0_base_reg, r0_mask_reg))
            rgn_cache = r0_base_reg[WTDC_RGN_CACHE_BIT];
        else if (in_region(lsu_req_i.addr, r1_base_reg, r1_mask_reg))
            rgn_cache = r1_base_reg[WTDC_RGN_CACHE_BIT];
        else
            rgn_cache = def_reg[WTDC_RGN_CACHE_BIT]; // RL3
        unique case (lsu_req_i.size)
            WTDC_SZ_DBL: req_last = 2'h1;
            WTDC_SZ_TRI: req_last = 2'h2;
            WTDC_SZ_QUAD: req_last = 2'h3;
            default: req_last = 2'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // Step decisions
    // ----------------------------------------------------------------
    logic step;
    logic last_step;
    logic [31:0] step_data;
    logic upd_full;
    logic upd_sub;
    logic upd_inv;
    logic aligned;
    logic [3:0] word_mask;

    assign step = (state_reg == ST_XFER && !need_reg[i_reg]) ||
                  (state_reg == ST_WAIT && ext_rsp_i.ack);
    assign last_step = step && i_reg == last_reg;
    assign step_data = req_reg.we ? req_reg.wdata[32*i_reg +: 32] :
                       (state_reg == ST_WAIT ? ext_rsp_i.rdata : cache_word);
    assign word_mask = 4'hf >> (2'h3 - last_reg);
    assign aligned = req_reg.size == WTDC_SZ_DBL ? req_reg.addr[2:0] == 3'h0 :
                     req_reg.addr[3:0] == 4'h0;

    always_comb
    begin
        upd_full = 1'b0;
        upd_sub = 1'b0;
        upd_inv = 1'b0;
        if (step)
        begin
            if (!cacheable_reg)
                upd_inv = word_hit && (req_reg.we || !enable_reg); // RL22 RL23
            else if (!req_reg.we)
                upd_full = any_miss_reg; // RL10
            else if (sub_word)
                upd_sub = line_hit; // RL18 RL19 RL20
            else
                upd_full = 1'b1; // RL16 RL17
        end
    end

    // ----------------------------------------------------------------
    // Cache arrays
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (upd_full)
        begin
            data_mem[{cur_idx, cur_w}] <= step_data; // RL1
            if (!line_hit)
                tag_mem[cur_idx] <= cur_tag; // RL16
        end
        else if (upd_sub)
        begin
            data_mem[{cur_idx, cur_w}] <= merge_lanes(cache_word, sub_data, sub_sel); // RL18
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            line_valid_reg <= '0; // RL4
            for (int l = 0; l < LINES; l++)
                word_valid_reg[l] <= 4'h0; // RL4
        end
        else if (upd_full)
        begin
            line_valid_reg[cur_idx] <= 1'b1;
            if (line_hit)
                word_valid_reg[cur_idx][cur_w] <= 1'b1; // RL17
            else
                word_valid_reg[cur_idx] <= 4'h1 << cur_w; // RL16
        end
        else if (upd_inv)
        begin
            word_valid_reg[cur_idx][cur_w] <= 1'b0; // RL22 RL23
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
            i_reg <= 2'h0;
            last_reg <= 2'h0;
            hit_reg <= 4'h0;
            cacheable_reg <= 1'b0;
            widen_reg <= 1'b0;
            lsu_ready_o <= 1'b0;
            lsu_rsp_o <= '0;
            ext_req_o <= '0;
        end
        else
        begin
            lsu_rsp_o.done <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                begin
                    lsu_ready_o <= 1'b1;
                    if (lsu_req_i.valid && lsu_ready_o)
                    begin
                        req_reg <= lsu_req_i;
                        cacheable_reg <= enable_reg && rgn_cache; // RL3 RL5 RL21
                        widen_reg <= rgn_cache; // RL14
                        last_reg <= req_last; // RL13
                        i_reg <= 2'h0;
                        hit_reg <= 4'h0;
                        lsu_ready_o <= 1'b0;
                        state_reg <= ST_SCAN;
                    end
                end
                ST_SCAN:
                begin
                    // One word per cycle keeps the tag compare single ported
                    hit_reg[i_reg] <= word_hit;
                    if (i_reg == last_reg)
                    begin
                        i_reg <= 2'h0;
                        state_reg <= ST_XFER;
                    end
                    else
                        i_reg <= i_reg + 2'h1;
                end
                ST_XFER:
                begin
                    if (need_reg[i_reg])
                    begin
                        ext_req_o.req <= 1'b1;
                        ext_req_o.we <= req_reg.we; // RL15
                        ext_req_o.addr <= {cur_wa, 2'b00};
                        ext_req_o.sel <= (sub_word && (req_reg.we || !widen_reg)) ?
                                         sub_sel : 4'hf; // RL14
                        ext_req_o.wdata <= step_data;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (ext_rsp_i.ack)
                    begin
                        ext_req_o.req <= 1'b0;
                        state_reg <= ST_XFER;
                    end
                end
            endcase
            if (step)
            begin
                if (!req_reg.we)
                    lsu_rsp_o.rdata[32*i_reg +: 32] <= step_data; // RL9
                i_reg <= i_reg + 2'h1;
                state_reg <= ST_XFER;
            end
            if (last_step)
            begin
                lsu_rsp_o.done <= 1'b1;
                lsu_ready_o <= 1'b1;
                state_reg <= ST_IDLE;
            end
        end
    end

    // Decision taken once the hit picture is complete
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            need_reg <= 4'h0;
            any_miss_reg <= 1'b0;
        end
        else if (state_reg == ST_SCAN && i_reg == last_reg)
        begin
            logic [3:0] hits;
            hits = (hit_reg | (4'h1 << i_reg)) & word_mask;
            if (!word_hit)
                hits = hit_reg & word_mask & ~(4'h1 << i_reg);
            any_miss_reg <= hits != word_mask; // RL10
            if (req_reg.we || !cacheable_reg)
                need_reg <= word_mask; // RL5 RL12 RL15
            else if (hits == word_mask)
                need_reg <= 4'h0; // RL11
            else if (hits == 4'h0 || aligned || last_reg == 2'h0)
                need_reg <= word_mask; // RL7 RL8 RL13
            else
                need_reg <= word_mask & ~hits; // RL9
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic wb_hit;
    logic [31:0] status_word;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[WTDC_ST_ENABLED_BIT] = enable_reg; // RL6
        status_word[WTDC_ST_BUSY_BIT] = state_reg != ST_IDLE;
        status_word[WTDC_ST_WORDS_LSB +: 4] = 4'(WTDC_LINE_WORDS);
        status_word[WTDC_ST_KB_LSB +: 8] = 8'(CACHE_KB);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            enable_reg <= WTDC_ENABLE_RST; // RL4
            r0_base_reg <= WTDC_RGN_RST;
            r0_mask_reg <= WTDC_MASK_RST;
            r1_base_reg <= WTDC_RGN_RST;
            r1_mask_reg <= WTDC_MASK_RST;
            def_reg <= WTDC_DEF_RST;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    WTDC_OFS_CMD: wb_dat_o <= {31'h0, enable_reg};
                    WTDC_OFS_STATUS: wb_dat_o <= status_word; // RL6
                    WTDC_OFS_R0_BASE: wb_dat_o <= r0_base_reg;
                    WTDC_OFS_R0_MASK: wb_dat_o <= r0_mask_reg;
                    WTDC_OFS_R1_BASE: wb_dat_o <= r1_base_reg;
                    WTDC_OFS_R1_MASK: wb_dat_o <= r1_mask_reg;
                    WTDC_OFS_DEFAULT: wb_dat_o <= def_reg;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
            if (wb_hit && wb_we_i)
            begin
                unique case (wb_adr_i)
                    WTDC_OFS_CMD:
                    begin
                        // Disable wins when both commands arrive together
                        if (wb_sel_i[0] && wb_dat_i[WTDC_CMD_DISABLE_BIT])
                            enable_reg <= 1'b0; // RL6
                        else if (wb_sel_i[0] && wb_dat_i[WTDC_CMD_ENABLE_BIT])
                            enable_reg <= 1'b1; // RL6
                    end
                    WTDC_OFS_R0_BASE: r0_base_reg <= merge_lanes(r0_base_reg, wb_dat_i, wb_sel_i);
                    WTDC_OFS_R0_MASK: r0_mask_reg <= merge_lanes(r0_mask_reg, wb_dat_i, wb_sel_i);
                    WTDC_OFS_R1_BASE: r1_base_reg <= merge_lanes(r1_base_reg, wb_dat_i, wb_sel_i);
                    WTDC_OFS_R1_MASK: r1_mask_reg <= merge_lanes(r1_mask_reg, wb_dat_i, wb_sel_i);
                    WTDC_OFS_DEFAULT: def_reg <= merge_lanes(def_reg, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end
    end

endmodule // wtdc_cache

// ---- test/wtdc_cache_assertions.sv ----
`timescale 1ns/1ps
// ----------------
// Port checks
// ----------------
module wtdc_cache_checker
    import wtdc_pkg::*;
#(
    parameter int CACHE_KB = WTDC_CACHE_KB_DEF
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire wtdc_lsu_req_t lsu_req_i,
    input wire logic lsu_ready_o,
    input wire wtdc_lsu_rsp_t lsu_rsp_o,
    input wire wtdc_ext_req_t ext_req_o,
    input wire wtdc_ext_rsp_t ext_rsp_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("register access not answered next cycle");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("register ack longer than one cycle");
    a_wb_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("register read data outside ack");
    a_ready_after_reset: assert property ($fell(rst_i) |=> lsu_ready_o)
        else $error("load store port not ready after reset");
    a_take_drops_ready: assert property (lsu_req_i.valid && lsu_ready_o |=> !lsu_ready_o)
        else $error("ready stayed high after a request was taken");
    a_done_pulse: assert property (lsu_rsp_o.done |=> !lsu_rsp_o.done)
        else $error("done longer than one cycle");
    a_store_on_bus: assert property (lsu_req_i.valid && lsu_req_i.we && lsu_ready_o
        |-> ##[2:12] (ext_req_o.req && ext_req_o.we))
        else $error("store never reached the external bus");
    a_ext_hold: assert property (ext_req_o.req && !ext_rsp_i.ack
        |=> ext_req_o.req && $stable(ext_req_o))
        else $error("bus request changed before ack");
    a_ext_release: assert property (ext_req_o.req && ext_rsp_i.ack |=> !ext_req_o.req)
        else $error("bus request held after ack");
    a_ext_aligned: assert property (ext_req_o.req |-> ext_req_o.addr[1:0] == 2'h0)
        else $error("bus address not word aligned");
    a_idle_no_bus: assert property (lsu_ready_o |-> !ext_req_o.req)
        else $error("bus request while idle");
endmodule // wtdc_cache_checker

bind wtdc_cache wtdc_cache_checker #(.CACHE_KB(CACHE_KB)) i_wtdc_cache_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lsu_req_i(lsu_req_i),
    .lsu_ready_o(lsu_ready_o), .lsu_rsp_o(lsu_rsp_o), .ext_req_o(ext_req_o),
    .ext_rsp_i(ext_rsp_i)
);

// ---- test/wtdc_bus_model.sv ----
`timescale 1ns/1ps
// ----------------
// External memory
// ----------------
module wtdc_bus_model
    import wtdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wtdc_ext_req_t req_i,
    input wire logic [3:0] lat_i,
    output wtdc_ext_rsp_t rsp_o,
    output logic [7:0] n_rd_o,
    output logic [7:0] n_wr_o,
    output logic [3:0] sel_o
);
    logic [31:0] mem [logic [31:0]];
    logic [3:0] wait_reg;
    logic [31:0] cur;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rsp_o <= '0;
            wait_reg <= 4'h0;
            n_rd_o <= 8'h0;
            n_wr_o <= 8'h0;
            sel_o <= 4'h0;
        end
        else if (rsp_o.ack || !req_i.req)
        begin
            // Released data line toggles so no stale word looks valid
            rsp_o.ack <= 1'b0;
            rsp_o.rdata <= ~rsp_o.rdata;
        end
        else if (wait_reg + 4'h1 < lat_i)
            wait_reg <= wait_reg + 4'h1;
        else
        begin
            cur = mem.exists(req_i.addr) ? mem[req_i.addr] : {req_i.addr[15:0], ~req_i.addr[15:0]};
            for (int b = 0; b < 4; b++)
                if (req_i.we && req_i.sel[b])
                    cur[8*b +: 8] = req_i.wdata[8*b +: 8];
            if (req_i.we)
                mem[req_i.addr] = cur;
            n_rd_o <= n_rd_o + {7'h0, !req_i.we};
            n_wr_o <= n_wr_o + {7'h0, req_i.we};
            sel_o <= req_i.sel;
            rsp_o <= '{1'b1, cur};
            wait_reg <= 4'h0;
        end
    end
endmodule // wtdc_bus_model

// ---- test/wtdc_cache_tb_top.sv ----
`timescale 1ns/1ps
// ----------------
// Bench
// ----------------
module wtdc_cache_tb_top
    import wtdc_pkg::*;
;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, lsu_ready;
    logic [7:0] wb_adr_i, n_rd, n_wr;
    logic [3:0] wb_sel_i, lat, bus_sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    wtdc_lsu_req_t lsu_req;
    wtdc_lsu_rsp_t lsu_rsp;
    wtdc_ext_req_t ext_req;
    wtdc_ext_rsp_t ext_rsp;
    logic [31:0] shadow [logic [31:0]];
    int errors, n_checks;

    wtdc_cache #(.CACHE_KB(1)) i_wtdc_cache (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .lsu_req_i(lsu_req), .lsu_ready_o(lsu_ready), .lsu_rsp_o(lsu_rsp),
        .ext_req_o(ext_req), .ext_rsp_i(ext_rsp));
    wtdc_bus_model i_wtdc_bus_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(ext_req),
        .lat_i(lat), .rsp_o(ext_rsp), .n_rd_o(n_rd), .n_wr_o(n_wr), .sel_o(bus_sel));

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] word_at(input logic [31:0] a);
        return shadow.exists(a) ? shadow[a] : {a[15:0], ~a[15:0]};
    endfunction

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (int n = 0; n < 64 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
        check(wb_ack_o, 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Bus count is words for stores, reads expected for loads
    task automatic lsu(input logic we, input wtdc_size_t sz, input logic [31:0] a,
        input logic [31:0] d, input logic [7:0] n_bus);
        logic [7:0] rd0, wr0;
        logic [127:0] exp, mask;
        int nw;
        rd0 = n_rd;
        wr0 = n_wr;
        nw = (sz < WTDC_SZ_WORD) ? 1 : int'(sz) - 1;
        @(posedge clk_i);
        lsu_req <= '{1'b1, we, sz, a, {d + 32'h3, d + 32'h2, d + 32'h1, d}};
        @(posedge clk_i);
        for (int n = 0; n < 64 && lsu_ready !== 1'b1; n++) @(posedge clk_i);
        lsu_req.valid <= 1'b0;
        for (int n = 0; n < 200 && lsu_rsp.done !== 1'b1; n++) @(posedge clk_i);
        check(lsu_rsp.done, 1'b1);
        exp = '0;
        mask = '0;
        for (int i = 0; i < nw; i++)
        begin
            exp[32*i +: 32] = word_at(a + 32'(4*i));
            mask[32*i +: 32] = 32'hffff_ffff;
            if (we && sz < WTDC_SZ_WORD)
                shadow[a] = {exp[31:8], d[7:0]};
            else if (we)
                shadow[a + 32'(4*i)] = d + 32'(i);
        end
        if (!we)
            check(lsu_rsp.rdata & mask, exp);
        check(we ? n_wr - wr0 : n_rd - rd0, n_bus);
    endtask

    task automatic t_reset();
        wb(1'b0, WTDC_OFS_STATUS, 32'h0);
        check(rd & 32'h0000_fff3, 32'h0000_0140);
        wb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, WTDC_OFS_DEFAULT, 32'h2);
        wb(1'b0, WTDC_OFS_DEFAULT, 32'h0);
        check(rd, 32'h2);
    endtask

    task automatic t_disabled();
        lsu(1'b0, WTDC_SZ_WORD, 32'h100, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h100, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_BYTE, 32'h104, 0, 8'h1);
        check(bus_sel, 4'hf);
    endtask

    task automatic t_fill();
        wb(1'b1, WTDC_OFS_CMD, 32'h1);
        wb(1'b0, WTDC_OFS_STATUS, 32'h0);
        check(rd[0], 1'b1);
        lat <= 4'h3;
        lsu(1'b0, WTDC_SZ_QUAD, 32'h100, 0, 8'h4);
        lsu(1'b0, WTDC_SZ_QUAD, 32'h100, 0, 8'h0);
        lat <= 4'h1;
        lsu(1'b0, WTDC_SZ_WORD, 32'h204, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_DBL, 32'h200, 0, 8'h2);
        lsu(1'b0, WTDC_SZ_DBL, 32'h200, 0, 8'h0);
        lsu(1'b0, WTDC_SZ_WORD, 32'h308, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_DBL, 32'h304, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_TRI, 32'h304, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_TRI, 32'h304, 0, 8'h0);
    endtask

    task automatic t_stores();
        lsu(1'b1, WTDC_SZ_WORD, 32'h400, 32'h1234_5678, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h400, 0, 8'h0);
        lsu(1'b0, WTDC_SZ_WORD, 32'h404, 0, 8'h1);
        lsu(1'b1, WTDC_SZ_QUAD, 32'h100, 32'hcafe_0000, 8'h4);
        lsu(1'b0, WTDC_SZ_QUAD, 32'h100, 0, 8'h0);
        lsu(1'b0, WTDC_SZ_WORD, 32'h50c, 0, 8'h1);
        lsu(1'b1, WTDC_SZ_WORD, 32'h900, 32'h0bad_f00d, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h90c, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h900, 0, 8'h0);
    endtask

    task automatic t_subword();
        lsu(1'b1, WTDC_SZ_BYTE, 32'h400, 32'ha5, 8'h1);
        check(bus_sel, 4'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h400, 0, 8'h0);
        lsu(1'b1, WTDC_SZ_BYTE, 32'h408, 32'h5a, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h408, 0, 8'h1);
        lsu(1'b1, WTDC_SZ_BYTE, 32'ha00, 32'h3c, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h204, 0, 8'h0);
    endtask

    task automatic t_uncached();
        wb(1'b1, WTDC_OFS_R0_BASE, 32'h0000_1001);
        wb(1'b1, WTDC_OFS_R0_MASK, 32'hffff_f000);
        lsu(1'b0, WTDC_SZ_WORD, 32'h1000, 0, 8'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h1000, 0, 8'h1);
        wb(1'b1, WTDC_OFS_CMD, 32'h2);
        lsu(1'b1, WTDC_SZ_WORD, 32'h400, 32'h7777_0001, 8'h1);
        wb(1'b1, WTDC_OFS_CMD, 32'h1);
        lsu(1'b0, WTDC_SZ_WORD, 32'h400, 0, 8'h1);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        complete_run();
    end

    initial
    begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        lsu_req = '0;
        lat = 4'h1;
        errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_disabled();
        t_fill();
        t_stores();
        t_subword();
        t_uncached();
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule // wtdc_cache_tb_top
